// ---- src/bridge_ctrl_pkg.sv ----
// Purpose: Shared constants and types for the bridge excitation controller
// Assumes: 100 MHz clock, 32-bit classic Wishbone register access
// Notes:   Byte offsets are word aligned
package bridge_ctrl_pkg;

  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned SETTLE_SHORT_US = 100;
  localparam int unsigned SETTLE_LONG_US  = 200;
  localparam int unsigned SETTLE_SHORT_CYC = SETTLE_SHORT_US * CLK_MHZ;
  localparam int unsigned SETTLE_LONG_CYC  = SETTLE_LONG_US * CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] MODE_OFS   = 8'h04;
  localparam logic [7:0] STAT_OFS   = 8'h08;
  localparam logic [7:0] MASK_OFS   = 8'h0c;
  localparam logic [7:0] DATA_OFS   = 8'h10;
  localparam logic [7:0] OFFCOEF_OFS = 8'h14;
  localparam logic [7:0] FSCOEF_OFS  = 8'h18;

  // Configuration field positions
  localparam int unsigned CFG_GAIN_LSB  = 0;
  localparam int unsigned CFG_UNIPOLAR  = 3;
  localparam int unsigned CFG_VREF_MON  = 4;
  localparam int unsigned CFG_OPEN_TEST = 5;
  localparam int unsigned CFG_ACX_EN    = 6;
  localparam int unsigned CFG_RATE_LSB  = 8;

  // Status bits (all sticky, write one to clear, missing vref included)
  localparam int unsigned ST_MISSING_VREF = 0;
  localparam int unsigned ST_FAULT        = 1;
  localparam int unsigned ST_DATA_READY   = 2;
  localparam int unsigned ST_CAL_DONE     = 3;

  localparam logic [31:0] CFG_RST     = 32'h0000_0100;
  localparam logic [23:0] OFFCOEF_RST = 24'h80_0000;
  localparam logic [23:0] FSCOEF_RST  = 24'h50_0000;
  localparam logic [23:0] ALL_ONES    = 24'hff_ffff;

  typedef enum logic [2:0] {
    MODE_CONT     = 3'b000,
    MODE_SINGLE   = 3'b001,
    MODE_IDLE     = 3'b010,
    MODE_PDOWN    = 3'b011,
    MODE_CAL_OFS  = 3'b100,
    MODE_CAL_FS   = 3'b101
  } op_mode_t;

  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_SETTLE = 2'b01,
    ST_CONV   = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic phase_a;
    logic phase_a_n;
    logic phase_b;
    logic phase_b_n;
  } excite_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] code;
  } sample_t;

endpackage

// ---- src/bridge_excitation_front_end_ctrl.sv ----
// Purpose: Control logic around a 24-bit sigma-delta front end with
//          ac bridge excitation drive
// Assumes: Modulator result arrives as a signed 24-bit word with a strobe
// Notes:   Registers over classic Wishbone, one level interrupt
//
// Behaviour
// - Front-end gain follows the three gain-select bits: 1,8,16,32,64,128.
// - Reference monitoring runs only while its enable bit is one.
// - Invalid reference while monitoring sets the missing-reference status flag.
// - Normal conversions report all ones while reference is missing.
// - Missing reference during calibration blocks coefficient update, sets fault.
// - Unipolar coding is straight binary, zero to all ones except the LSB, which stays zero.
// - Bipolar coding is offset binary, zero input gives only MSB set.
// - Polarity-select bit chooses unipolar or bipolar range and coding.
// - Both open-circuit test currents switch on or off together.
// - Two complementary excitation pairs never change in overlapping cycles.
// - AC mode reverses polarity every conversion cycle, sampling kept in step.
// - Settle 100 us after each switch when rate is one, else 200 us.
// - Excitation switching rate scales with the programmed output rate; code switches per modulator result, rate only picks the settle.
// - AC disabled: phase A and inverted B high, others low.
// - Power-down: true outputs low, inverted outputs high.
// - Single mode converts once then powers down, outputs disconnected.
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module bridge_excitation_front_end_ctrl
  import bridge_ctrl_pkg::*;
#(
  parameter int unsigned SHORT_SETTLE = SETTLE_SHORT_CYC,
  parameter int unsigned LONG_SETTLE  = SETTLE_LONG_CYC
)(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Analog front end
  input  wire logic        vref_invalid_i,
  input  wire logic        mod_rdy_i,
  input  wire logic [23:0] mod_result_i,
  output logic      [2:0]  pga_gain_sel_o,
  output logic             bipolar_range_o,
  output logic             test_current_src_o,
  output logic             test_current_snk_o,
  output logic             front_end_power_o,
  output logic             sample_enable_o,
  // Bridge drive
  output excite_t          excite_o,
  // Interrupt
  output logic             irq_o
);

  logic [31:0] cfg_q;
  op_mode_t    mode_q;
  logic [3:0]  status_q;
  logic [3:0]  mask_q;
  logic [23:0] data_q;
  logic [23:0] offcoef_q;
  logic [23:0] fscoef_q;
  seq_state_t  state_q;
  logic [15:0] settle_q;
  logic        polarity_q;
  logic        gap_q;
  logic        cal_bad_q;
  excite_t     excite_d;
  sample_t     coded;

  wire       wr_stb    = cyc_i && stb_i && we_i && !ack_o;
  wire       rd_stb    = cyc_i && stb_i && !ack_o;
  wire [9:0] rate      = cfg_q[CFG_RATE_LSB +: 10];
  wire       unipolar  = cfg_q[CFG_UNIPOLAR];
  wire       ac_en     = cfg_q[CFG_ACX_EN];
  wire       mon_en    = cfg_q[CFG_VREF_MON];
  wire       missing   = mon_en && vref_invalid_i;
  wire       calib     = (mode_q == MODE_CAL_OFS) || (mode_q == MODE_CAL_FS);
  wire       running   = (mode_q == MODE_CONT) || (mode_q == MODE_SINGLE) ||
                         calib;
  wire       conv_done = (state_q == ST_CONV) && mod_rdy_i;

  // Merge byte lanes into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  function automatic logic [15:0] settle_len(input logic [9:0] fs);
    logic [15:0] r;
    r = (fs == 10'h001) ? 16'(SHORT_SETTLE) : 16'(LONG_SETTLE);
    return r;
  endfunction

  // Modulator word is two's complement; bipolar adds half scale
  always_comb
  begin
    coded.valid = conv_done;
    if (unipolar)
      coded.code = mod_result_i[23] ? 24'h00_0000
                                    : {mod_result_i[22:0], 1'b0};
    else
      coded.code = {~mod_result_i[23], mod_result_i[22:0]};
  end

  // Bus acknowledge, one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      dat_o <= 32'h0000_0000;
    else if (rd_stb)
    begin
      case (adr_i)
        CFG_OFS:     dat_o <= cfg_q;
        MODE_OFS:    dat_o <= {29'h0, mode_q};
        STAT_OFS:    dat_o <= {28'h0, status_q};
        MASK_OFS:    dat_o <= {28'h0, mask_q};
        DATA_OFS:    dat_o <= {8'h00, data_q};
        OFFCOEF_OFS: dat_o <= {8'h00, offcoef_q};
        FSCOEF_OFS:  dat_o <= {8'h00, fscoef_q};
        default:     dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cfg_q <= CFG_RST;
    else if (wr_stb && adr_i == CFG_OFS)
      cfg_q <= lane_merge(cfg_q, dat_i, sel_i) & 32'h0003_ff7f;
  end

  // Single conversion and calibrations fall back to power-down
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      mode_q <= MODE_PDOWN;
    else if (wr_stb && adr_i == MODE_OFS && sel_i[0])
      mode_q <= op_mode_t'(dat_i[2:0]);
    else if (conv_done && mode_q != MODE_CONT)
      mode_q <= MODE_PDOWN;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      mask_q <= 4'h0;
    else if (wr_stb && adr_i == MASK_OFS && sel_i[0])
      mask_q <= dat_i[3:0];
  end

  // Sticky events; a set in the clearing cycle wins
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      status_q <= 4'h0;
    else
    begin
      logic [3:0] clr;
      logic [3:0] set;
      clr = (wr_stb && adr_i == STAT_OFS && sel_i[0]) ? dat_i[3:0] : 4'h0;
      set = 4'h0;
      set[ST_MISSING_VREF] = missing;
      set[ST_FAULT]        = conv_done && calib && (cal_bad_q || missing);
      set[ST_DATA_READY]   = conv_done && !calib;
      set[ST_CAL_DONE]     = conv_done && calib;
      status_q <= (status_q & ~clr) | set;
    end
  end

  // Reference loss anywhere in a calibration spoils it
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cal_bad_q <= 1'b0;
    else if (!calib || conv_done)
      cal_bad_q <= 1'b0;
    else if (missing)
      cal_bad_q <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      data_q <= 24'h00_0000;
    else if (coded.valid && !calib)
      data_q <= missing ? ALL_ONES : coded.code;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      offcoef_q <= OFFCOEF_RST;
    else if (wr_stb && adr_i == OFFCOEF_OFS && !running)
      offcoef_q <= 24'(lane_merge({8'h00, offcoef_q}, dat_i, sel_i));
    else if (conv_done && mode_q == MODE_CAL_OFS && !cal_bad_q && !missing)
      offcoef_q <= coded.code;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      fscoef_q <= FSCOEF_RST;
    else if (wr_stb && adr_i == FSCOEF_OFS && !running)
      fscoef_q <= 24'(lane_merge({8'h00, fscoef_q}, dat_i, sel_i));
    else if (conv_done && mode_q == MODE_CAL_FS && !cal_bad_q && !missing)
      fscoef_q <= coded.code;
  end

  // Conversion sequencer: settle, then convert
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_q  <= ST_OFF;
      settle_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_OFF:
        begin
          if (running)
          begin
            state_q  <= ST_SETTLE;
            settle_q <= settle_len(rate);
          end
        end
        ST_SETTLE:
        begin
          if (!running)
            state_q <= ST_OFF;
          else if (settle_q <= 16'h0001)
            state_q <= ST_CONV;
          else
            settle_q <= settle_q - 16'h0001;
        end
        ST_CONV:
        begin
          if (!running || (conv_done && mode_q != MODE_CONT))
            state_q <= ST_OFF;
          else if (conv_done && ac_en)
          begin
            state_q  <= ST_SETTLE;
            settle_q <= settle_len(rate);
          end
        end
        default:
          state_q <= ST_OFF;
      endcase
    end
  end

  // Switch every conversion; conversion period is the settle plus the wait for the modulator strobe
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      polarity_q <= 1'b0;
    else if (!ac_en || !running)
      polarity_q <= 1'b0;
    else if (conv_done)
      polarity_q <= ~polarity_q;
  end

  always_comb
  begin
    if (!running)
      excite_d = '{phase_a: 1'b0, phase_a_n: 1'b1,
                   phase_b: 1'b0, phase_b_n: 1'b1};
    else if (!ac_en || !polarity_q)
      excite_d = '{phase_a: 1'b1, phase_a_n: 1'b0,
                   phase_b: 1'b0, phase_b_n: 1'b1};
    else
      excite_d = '{phase_a: 1'b0, phase_a_n: 1'b1,
                   phase_b: 1'b1, phase_b_n: 1'b0};
  end

  // Break-before-make: one cycle with all switches open on any change
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      excite_o <= '{phase_a: 1'b0, phase_a_n: 1'b1,
                    phase_b: 1'b0, phase_b_n: 1'b1};
      gap_q    <= 1'b0;
    end
    else if (excite_d != excite_o && !gap_q)
    begin
      excite_o <= '{phase_a: 1'b0, phase_a_n: 1'b1,
                    phase_b: 1'b0, phase_b_n: 1'b1};
      gap_q    <= 1'b1;
    end
    else
    begin
      excite_o <= excite_d;
      gap_q    <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pga_gain_sel_o     <= 3'b000;
      bipolar_range_o    <= 1'b0;
      test_current_src_o <= 1'b0;
      test_current_snk_o <= 1'b0;
      front_end_power_o  <= 1'b0;
      sample_enable_o    <= 1'b0;
      irq_o              <= 1'b0;
    end
    else
    begin
      pga_gain_sel_o     <= cfg_q[CFG_GAIN_LSB +: 3];
      bipolar_range_o    <= !unipolar;
      test_current_src_o <= cfg_q[CFG_OPEN_TEST];
      test_current_snk_o <= cfg_q[CFG_OPEN_TEST];
      front_end_power_o  <= running;
      sample_enable_o    <= (state_q == ST_CONV) && !gap_q;
      irq_o              <= |(status_q & mask_q);
    end
  end

  a_test_pair_same: assert property (@(posedge clk_i) disable iff (srst_i)
    test_current_src_o == test_current_snk_o)
    else $error("test currents differ");

  a_pdown_outputs: assert property (@(posedge clk_i) disable iff (srst_i)
    (!running && !gap_q) [*2] |->
      excite_o == 4'b0101)
    else $error("power-down drive wrong");

  a_no_overlap: assert property (@(posedge clk_i) disable iff (srst_i)
    !(excite_o.phase_a && excite_o.phase_b))
    else $error("both phases on");

  a_gap_on_flip: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(excite_o.phase_b) |-> $past(excite_o) == 4'b0101)
    else $error("no gap before phase b");

  a_dc_static: assert property (@(posedge clk_i) disable iff (srst_i)
    (running && !ac_en) [*3] |-> excite_o == 4'b1001)
    else $error("dc drive wrong");

  a_clamp_ones: assert property (@(posedge clk_i) disable iff (srst_i)
    conv_done && !calib && missing |=> data_q == ALL_ONES)
    else $error("result not clamped");

  a_cal_inhibit: assert property (@(posedge clk_i) disable iff (srst_i)
    conv_done && mode_q == MODE_CAL_OFS && missing
      |=> $stable(offcoef_q) && status_q[ST_FAULT])
    else $error("calibration not inhibited");

  a_missing_vref_flag_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    missing |=> status_q[ST_MISSING_VREF])
    else $error("missing flag not set");

  a_single_ends: assert property (@(posedge clk_i) disable iff (srst_i)
    conv_done && mode_q == MODE_SINGLE && !wr_stb
      |=> mode_q == MODE_PDOWN)
    else $error("single mode did not stop");

  a_settle_load: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == ST_CONV && conv_done && ac_en && running
      && mode_q == MODE_CONT
      |=> state_q == ST_SETTLE && settle_q == settle_len($past(rate)))
    else $error("settle not restarted");

endmodule

// ---- sim/bridge_switch_model.sv ----
// Purpose: Bridge switching transistors seen from the drive outputs
// Assumes: Drive outputs are registered on clk_i
// Notes:   Counts cycles where both pairs switch at once
`timescale 1ns/1ps
module bridge_switch_model
  import bridge_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic    clk_i,
  input  wire logic    srst_i,
  // Drive from the block
  input  wire excite_t excite_i,
  // Fault count
  output int           overlap_o
);
  excite_t last_q;

  // Both pairs moving together would short the bridge supply
  always_ff @(posedge clk_i)
  begin
    last_q <= excite_i;
    if (srst_i)
      overlap_o <= 0;
    else if ({last_q.phase_a, last_q.phase_a_n}
             != {excite_i.phase_a, excite_i.phase_a_n} &&
             {last_q.phase_b, last_q.phase_b_n}
             != {excite_i.phase_b, excite_i.phase_b_n})
      overlap_o <= overlap_o + 1;
  end
endmodule

// ---- sim/bridge_excitation_front_end_ctrl_tb_top.sv ----
// Purpose: Self-checking bench for the bridge excitation controller
// Assumes: Settle counts shortened to 10 and 20 cycles
// Notes:   Front-end result is driven by the bench
`timescale 1ns/1ps
module bridge_excitation_front_end_ctrl_tb_top;
  import bridge_ctrl_pkg::*;
  localparam int SH = 10;
  localparam int LG = 20;
  logic        clk_i, srst_i, cyc, stb, we, mrdy, vbad;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wd, rd, dat_o;
  logic [23:0] res;
  logic [2:0]  gain;
  logic        ack, bip, src, snk, pwr, sen, irq;
  excite_t     ex, e0;
  int          bad_count, cmp_count, ovl;

  bridge_excitation_front_end_ctrl #(.SHORT_SETTLE(SH), .LONG_SETTLE(LG))
  dut_u (.clk_i(clk_i), .srst_i(srst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(dat_o),
    .ack_o(ack), .vref_invalid_i(vbad), .mod_rdy_i(mrdy),
    .mod_result_i(res), .pga_gain_sel_o(gain), .bipolar_range_o(bip),
    .test_current_src_o(src), .test_current_snk_o(snk),
    .front_end_power_o(pwr), .sample_enable_o(sen), .excite_o(ex),
    .irq_o(irq));

  bridge_switch_model sw_u (.clk_i(clk_i), .srst_i(srst_i),
    .excite_i(ex), .overlap_o(ovl));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One classic cycle; waits for ack, only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d; sel <= 4'hf;
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic run(input logic [31:0] cfg, input logic [2:0] md);
    wb(1, MODE_OFS, 32'h3);
    wb(1, CFG_OFS, cfg);
    wb(1, MODE_OFS, {29'h0, md});
    // Drive passes through its open gap before the new pattern
    repeat (2) @(posedge clk_i);
  endtask

  // Waits for the convert window, then hands over one result
  task automatic conv(input logic [23:0] r);
    int n;
    n = 0;
    while (sen !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(sen, 1);
    res <= r; mrdy <= 1'b1;
    @(posedge clk_i);
    mrdy <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic t_reset;
    chk(ex, 4'h5);
    wb(0, CFG_OFS, 0);
    chk(rd, CFG_RST);
    wb(0, 8'h40, 0);
    chk(rd, 0);
    $display("reset test done");
  endtask

  task automatic t_cfg;
    for (int g = 0; g < 8; g++)
    begin
      wb(1, CFG_OFS, 32'h128 | g);
      @(posedge clk_i);
      chk(gain, g[2:0]);
      chk({src, snk}, 2'b11);
      chk(bip, 0);
    end
    wb(1, CFG_OFS, 32'h100);
    @(posedge clk_i);
    chk({src, snk, bip}, 3'b001);
    $display("config test done");
  endtask

  task automatic t_coding;
    run(32'h100, 3'h0);
    chk(ex, 4'h9);
    conv(24'h000000);
    wb(0, DATA_OFS, 0);
    chk(rd, 32'h80_0000);
    run(32'h108, 3'h0);
    conv(24'h400000);
    wb(0, DATA_OFS, 0);
    chk(rd, 32'h80_0000);
    conv(24'hc00000);
    wb(0, DATA_OFS, 0);
    chk(rd, 0);
    $display("coding test done");
  endtask

  task automatic t_vref;
    vbad <= 1'b1;
    run(32'h100, 3'h0);
    conv(24'h000010);
    wb(0, STAT_OFS, 0);
    chk(rd[0], 0);
    run(32'h110, 3'h0);
    wb(1, MASK_OFS, 32'h1);
    conv(24'h000010);
    wb(0, DATA_OFS, 0);
    chk(rd, ALL_ONES);
    wb(0, STAT_OFS, 0);
    chk(rd[0], 1);
    chk(irq, 1);
    vbad <= 1'b0;
    wb(1, STAT_OFS, 32'hf);
    repeat (2) @(posedge clk_i);
    chk(irq, 0);
    wb(1, MASK_OFS, 0);
    $display("reference test done");
  endtask

  task automatic t_cal;
    vbad <= 1'b1;
    run(32'h110, 3'h4);
    conv(24'h000123);
    wb(0, STAT_OFS, 0);
    chk(rd[1], 1);
    wb(0, OFFCOEF_OFS, 0);
    chk(rd, OFFCOEF_RST);
    vbad <= 1'b0;
    wb(1, STAT_OFS, 32'hf);
    run(32'h100, 3'h5);
    conv(24'h000123);
    wb(0, FSCOEF_OFS, 0);
    chk(rd, 32'h80_0123);
    wb(0, STAT_OFS, 0);
    chk(rd[1], 0);
    wb(1, MODE_OFS, 32'h2);
    wb(1, OFFCOEF_OFS, 32'h12_3456);
    wb(0, OFFCOEF_OFS, 0);
    chk(rd, 32'h12_3456);
    $display("calibration test done");
  endtask

  task automatic t_ac;
    int n;
    run(32'h240, 3'h0);
    conv(24'h000001);
    e0 = ex;
    conv(24'h000001);
    n = 0;
    while (sen !== 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(ex, {~e0});
    chk(n + 4 >= LG && n <= LG + 2, 1);
    run(32'h140, 3'h0);
    conv(24'h000001);
    e0 = ex;
    conv(24'h000001);
    chk(ex, {~e0});
    n = 0;
    while (sen !== 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(n, SH - 1);
    $display("ac test done");
  endtask

  task automatic t_single;
    run(32'h100, 3'h1);
    conv(24'h000002);
    repeat (4) @(posedge clk_i);
    chk({pwr, ex}, 5'h05);
    chk(ovl, 0);
    $display("single test done");
  endtask

  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    #200000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    bad_count = 0; cmp_count = 0;
    srst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wd = 0;
    mrdy = 0; vbad = 0; res = 0;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_cfg();
    t_coding();
    t_vref();
    t_cal();
    t_ac();
    t_single();
    end_of_test();
  end
endmodule
